// [pgd_port_fgh.sv]
`timescale 1ns/1ps
`include "pgd_params.svh"

module pgd_port_fgh (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // register bus
  input  wire pgd_pkg::pgd_axi_req_t  axi_req,
  output      pgd_pkg::pgd_axi_rsp_t  axi_rsp,
  // pins
  input  wire logic [7:0]             first_group_pin_in,
  input  wire logic [7:0]             second_group_pin_in,
  input  wire logic [7:0]             third_group_pin_in,
  output      logic                   third_group_pin7_out,
  output      logic                   third_group_pin7_oe,
  // pull-up enables
  output      logic [23:0]            pullup_en
);

  // per bit: input modes return the pin, other modes read low
  function automatic logic [7:0] read_group(input pgd_pkg::pgd_fn_pair_t fn,
                                            input logic [7:0] pins);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      v[i] = fn.hi[i] ? pins[i] : 1'b0;
    end
    return v;
  endfunction : read_group

  function automatic pgd_pkg::pgd_fn_pair_t write_fn(input pgd_pkg::pgd_fn_pair_t old,
                                                     input logic [31:0] data,
                                                     input logic [3:0] strb);
    pgd_pkg::pgd_fn_pair_t n;
    n = old;
    if (strb[0]) begin
      n.lo = data[7:0];
    end
    if (strb[1]) begin
      n.hi = data[15:8];
    end
    return n;
  endfunction : write_fn

  function automatic logic is_mapped(input logic [31:0] a);
    logic m;
    m = 1'b0;
    if (a == `PGD_F_ADDR) begin
      m = 1'b1;
    end else if (a == `PGD_G_ADDR) begin
      m = 1'b1;
    end else if (a == `PGD_H_ADDR) begin
      m = 1'b1;
    end else if (a == `PGD_FN_F_ADDR) begin
      m = 1'b1;
    end else if (a == `PGD_FN_G_ADDR) begin
      m = 1'b1;
    end else if (a == `PGD_FN_H_ADDR) begin
      m = 1'b1;
    end
    return m;
  endfunction : is_mapped

  // pin synchronisers
  logic [23:0] pin_s1_q;
  logic [23:0] pin_s2_q;
  logic [23:0] pin_s3_q;
  logic [23:0] pin_q;
  logic [23:0] pin_raw;

  assign pin_raw = {third_group_pin_in, second_group_pin_in, first_group_pin_in};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 24'h00_0000;
      pin_s2_q <= 24'h00_0000;
      pin_s3_q <= 24'h00_0000;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // a level counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 24'h00_0000;
    end else begin
      pin_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  // function settings
  pgd_pkg::pgd_fn_pair_t fn_f_q;
  pgd_pkg::pgd_fn_pair_t fn_g_q;
  pgd_pkg::pgd_fn_pair_t fn_h_q;
  logic                  store_h7_q;

  // write channel
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [31:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;

  assign wr_go = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      waddr_q   <= 32'h0000_0000;
    end else if (axi_req.awvalid && awready_q) begin
      awready_q <= 1'b0;
      waddr_q   <= axi_req.awaddr;
    end else if (bvalid_q && axi_req.bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wready_q <= 1'b1;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (axi_req.wvalid && wready_q) begin
      wready_q <= 1'b0;
      wdata_q  <= axi_req.wdata;
      wstrb_q  <= axi_req.wstrb;
    end else if (bvalid_q && axi_req.bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `PGD_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(waddr_q) ? `PGD_RESP_OKAY : `PGD_RESP_SLVERR;
    end else if (bvalid_q && axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // settings reset to input with pull-up
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fn_f_q <= `PGD_FN_RESET;
      fn_g_q <= `PGD_FN_RESET;
      fn_h_q <= `PGD_FN_RESET;
    end else if (wr_go) begin
      if (waddr_q == `PGD_FN_F_ADDR) begin
        fn_f_q <= write_fn(fn_f_q, wdata_q, wstrb_q);
      end else if (waddr_q == `PGD_FN_G_ADDR) begin
        fn_g_q <= write_fn(fn_g_q, wdata_q, wstrb_q);
      end else if (waddr_q == `PGD_FN_H_ADDR) begin
        fn_h_q <= write_fn(fn_h_q, wdata_q, wstrb_q);
      end
    end
  end

  // third group bit 7: every write with byte 0 strobed stores, whatever the mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_h7_q <= `PGD_H_STORE_RST;
    end else if (wr_go && waddr_q == `PGD_H_ADDR && wstrb_q[0]) begin
      store_h7_q <= wdata_q[`PGD_H_STORE];
    end
  end

  // pin drive for third group bit 7
  logic pin7_out_q;
  logic pin7_oe_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin7_out_q <= 1'b0;
      pin7_oe_q  <= 1'b0;
    end else begin
      pin7_out_q <= store_h7_q;
      pin7_oe_q  <= {fn_h_q.hi[7], fn_h_q.lo[7]} == `PGD_FN_OUT;
    end
  end

  logic [23:0] pullup_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_q <= 24'h00_0000;
    end else begin
      pullup_q <= {fn_h_q.hi & ~fn_h_q.lo, fn_g_q.hi & ~fn_g_q.lo,
                   fn_f_q.hi & ~fn_f_q.lo};
    end
  end

  // read channel
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] raddr_q;
  logic        rd_go;
  logic [7:0]  h_read;

  assign rd_go = !arready_q && !rvalid_q;

  always_comb begin
    h_read = read_group(fn_h_q, pin_q[23:16]);
    if (fn_h_q.hi[7]) begin
      h_read[7] = pin_q[23];
    end else begin
      h_read[7] = store_h7_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      raddr_q   <= 32'h0000_0000;
    end else if (axi_req.arvalid && arready_q) begin
      arready_q <= 1'b0;
      raddr_q   <= axi_req.araddr;
    end else if (rvalid_q && axi_req.rready) begin
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `PGD_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `PGD_RESP_OKAY;
      if (raddr_q == `PGD_F_ADDR) begin
        rdata_q <= {24'h00_0000, read_group(fn_f_q, pin_q[7:0])};
      end else if (raddr_q == `PGD_G_ADDR) begin
        rdata_q <= {24'h00_0000, read_group(fn_g_q, pin_q[15:8])};
      end else if (raddr_q == `PGD_H_ADDR) begin
        rdata_q <= {24'h00_0000, h_read};
      end else if (raddr_q == `PGD_FN_F_ADDR) begin
        rdata_q <= {16'h0000, fn_f_q};
      end else if (raddr_q == `PGD_FN_G_ADDR) begin
        rdata_q <= {16'h0000, fn_g_q};
      end else if (raddr_q == `PGD_FN_H_ADDR) begin
        rdata_q <= {16'h0000, fn_h_q};
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= `PGD_RESP_SLVERR;
      end
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign axi_rsp.awready      = awready_q;
  assign axi_rsp.wready       = wready_q;
  assign axi_rsp.bresp        = bresp_q;
  assign axi_rsp.bvalid       = bvalid_q;
  assign axi_rsp.arready      = arready_q;
  assign axi_rsp.rdata        = rdata_q;
  assign axi_rsp.rresp        = rresp_q;
  assign axi_rsp.rvalid       = rvalid_q;
  assign third_group_pin7_out = pin7_out_q;
  assign third_group_pin7_oe  = pin7_oe_q;
  assign pullup_en            = pullup_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_store_on_write:
    assert property ((wr_go && waddr_q == `PGD_H_ADDR && wstrb_q[0])
                     |=> store_h7_q == $past(wdata_q[7]))
    else $error("third group bit 7 did not take the written value");

  a_drive_in_output:
    assert property (({fn_h_q.hi[7], fn_h_q.lo[7]} == `PGD_FN_OUT) |=> pin7_oe_q
                     && pin7_out_q == $past(store_h7_q))
    else $error("output mode does not drive the stored bit");

  a_no_drive_other:
    assert property (({fn_h_q.hi[7], fn_h_q.lo[7]} != `PGD_FN_OUT) |=> !pin7_oe_q)
    else $error("pin driven outside output mode");

  a_reserved_zero:
    assert property ((rd_go && raddr_q == `PGD_F_ADDR && fn_f_q.hi == 8'h00)
                     |=> rvalid_q && rdata_q == 32'h0000_0000)
    else $error("non-input first group bits did not read zero");

  a_input_level:
    assert property ((rd_go && raddr_q == `PGD_G_ADDR && fn_g_q.hi == 8'hFF)
                     |=> rdata_q[7:0] == $past(pin_q[15:8]))
    else $error("input mode read is not the pin level");

  a_low_bits_zero:
    assert property ((rd_go && raddr_q == `PGD_H_ADDR && fn_h_q.hi[6:0] == 7'h00)
                     |=> rdata_q[6:0] == 7'h00)
    else $error("third group low bits not low outside input");

  a_sync_agree:
    assert property ((pin_q != $past(pin_q))
                     |-> (($past(pin_s2_q) ~^ $past(pin_s3_q)) | ~(pin_q ^ $past(pin_q)))
                         == 24'hFF_FFFF)
    else $error("pin level taken before two stages agreed");

  a_read_answer:
    assert property ((axi_req.arvalid && arready_q) |=> !arready_q ##1 rvalid_q)
    else $error("read answer not two cycles after address");

  a_bit7_retained:
    assert property (!(wr_go && waddr_q == `PGD_H_ADDR && wstrb_q[0])
                     |=> $stable(store_h7_q))
    else $error("third group bit 7 changed without a write");

  a_bit7_read_store:
    assert property ((rd_go && raddr_q == `PGD_H_ADDR && !fn_h_q.hi[7])
                     |=> rdata_q[7] == $past(store_h7_q))
    else $error("third group bit 7 read is not the stored bit");

  a_bit7_read_pin:
    assert property ((rd_go && raddr_q == `PGD_H_ADDR && fn_h_q.hi[7])
                     |=> rdata_q[7] == $past(pin_q[23]))
    else $error("third group bit 7 read is not the pin level");

  a_first_upper_zero:
    assert property ((rd_go && raddr_q == `PGD_F_ADDR)
                     |=> rvalid_q && rresp_q == `PGD_RESP_OKAY && rdata_q[31:8] == 24'h00_0000)
    else $error("first group read carries more than eight bits");

  a_pullup_on_setting:
    assert property ((fn_g_q.hi[0] && !fn_g_q.lo[0]) |=> pullup_q[8])
    else $error("pull-up off although the setting asks for it");

  a_pullup_off_plain:
    assert property ((fn_f_q.hi[0] && fn_f_q.lo[0]) |=> !pullup_q[0])
    else $error("pull-up on in input without pull-up");

endmodule : pgd_port_fgh

// [pgd_params.svh]
// What this block does
// - first group reads its eight pin levels
// - input modes read the synchronised pin level, once stages two and three agree
// - first two groups ignore writes; reserved reads zero
// - reset sets every pin to input, pull-up from the first clock after release
// - second group read-only pin levels register
// - per-pin pull-up enable from its own setting
// - third group bit 7 stored, bits 6-0 read-only
// - power-on reset clears bit 7; after that only a write changes it
// - output mode reads stored bit, drives it out
// - other modes store the write, pin unchanged
// - bits 6-0 low unless input; writes ignored
// - setting 00 alt, 01 out, 10 pull-up, 11 plain
`ifndef PGD_PARAMS_SVH
`define PGD_PARAMS_SVH

`define PGD_F_IDX      32'h0400_012A
`define PGD_G_IDX      32'h0400_012C
`define PGD_H_IDX      32'h0400_012E
`define PGD_F_ADDR     (`PGD_F_IDX << 2)
`define PGD_G_ADDR     (`PGD_G_IDX << 2)
`define PGD_H_ADDR     (`PGD_H_IDX << 2)
`define PGD_FN_F_ADDR  32'h1000_0500
`define PGD_FN_G_ADDR  32'h1000_0504
`define PGD_FN_H_ADDR  32'h1000_0508

`define PGD_FN_ALT     2'h0
`define PGD_FN_OUT     2'h1
`define PGD_FN_IN_PU   2'h2
`define PGD_FN_IN_NOPU 2'h3
`define PGD_FN_RESET   16'hFF00

`define PGD_H_STORE    7
`define PGD_H_STORE_RST 1'h0
`define PGD_RESP_OKAY  2'h0
`define PGD_RESP_SLVERR 2'h2

`endif

// [pgd_pkg.sv]
package pgd_pkg;

  typedef logic [1:0] pgd_fn_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } pgd_fn_pair_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } pgd_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } pgd_axi_rsp_t;

endpackage : pgd_pkg

// [pgd_pin_model.sv]
`timescale 1ns/1ps
module pgd_pin_model (
  // bench side
  input  wire logic [23:0] ext_lvl,
  input  wire logic        ext7_drv,
  // block side
  input  wire logic [23:0] pullup_en,
  input  wire logic        pin7_out,
  input  wire logic        pin7_oe,
  // pin levels
  output      logic [7:0]  f_pins,
  output      logic [7:0]  g_pins,
  output      logic [7:0]  h_pins
);
  logic h7;
  // released pin 7 floats to the inverse of the last level unless pulled up
  always_comb begin
    if (pin7_oe) h7 = pin7_out;
    else if (ext7_drv) h7 = ext_lvl[23];
    else h7 = pullup_en[23] | ~ext_lvl[23];
  end
  assign f_pins = ext_lvl[7:0];
  assign g_pins = ext_lvl[15:8];
  assign h_pins = {h7, ext_lvl[22:16]};
endmodule : pgd_pin_model

// [test_pgd_port_fgh.sv]
`timescale 1ns/1ps
`include "pgd_params.svh"
module test_pgd_port_fgh;
  logic                  sys_clk;
  logic                  rst_n;
  pgd_pkg::pgd_axi_req_t req;
  pgd_pkg::pgd_axi_rsp_t rsp;
  logic [7:0]            f_pins, g_pins, h_pins;
  logic                  pin7_out, pin7_oe, ext7_drv, stored;
  logic [23:0]           pullup_en, ext_lvl;
  logic [15:0]           fn [3];
  logic [31:0]           rd, d;
  logic [1:0]            resp;
  int                    error_cnt, samples_checked;

  pgd_port_fgh DUT (.sys_clk(sys_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
    .first_group_pin_in(f_pins), .second_group_pin_in(g_pins), .third_group_pin_in(h_pins),
    .third_group_pin7_out(pin7_out), .third_group_pin7_oe(pin7_oe), .pullup_en(pullup_en));
  pgd_pin_model PINS (.ext_lvl(ext_lvl), .ext7_drv(ext7_drv), .pullup_en(pullup_en),
    .pin7_out(pin7_out), .pin7_oe(pin7_oe), .f_pins(f_pins), .g_pins(g_pins), .h_pins(h_pins));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end

  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge sys_clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (!aw_done && rsp.awready === 1'b1) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_done && rsp.wready === 1'b1) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge sys_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge sys_clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge sys_clk); while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : axi_rd

  // data registers are reached at plain uncached addresses only
  function automatic logic [31:0] dat_addr(input int g);
    return (g == 0) ? `PGD_F_ADDR : (g == 1) ? `PGD_G_ADDR : `PGD_H_ADDR;
  endfunction : dat_addr

  function automatic logic [7:0] exp_rd(input int g);
    logic [7:0] v, p;
    logic [1:0] m;
    v = 8'h00;
    p = ext_lvl[g*8+:8];
    for (int k = 0; k < 8; k++) begin
      m = {fn[g][k+8], fn[g][k]};
      if (g == 2 && k == 7) p[7] = ext7_drv ? ext_lvl[23] : (m == `PGD_FN_IN_PU) | ~ext_lvl[23];
      if (m[1]) v[k] = p[k];
      else if (g == 2 && k == 7) v[k] = stored;
    end
    return v;
  endfunction : exp_rd

  function automatic logic [23:0] exp_pu();
    logic [23:0] v;
    for (int i = 0; i < 24; i++) v[i] = ({fn[i/8][i%8+8], fn[i/8][i%8]} == `PGD_FN_IN_PU);
    return v;
  endfunction : exp_pu

  task automatic set_fn(input int g, input logic [15:0] v);
    fn[g] = v;
    axi_wr(`PGD_FN_F_ADDR + 32'(4 * g), {16'h0000, v}, resp);
  endtask : set_fn

  task automatic check_all();
    for (int g = 0; g < 3; g++) begin
      axi_rd(dat_addr(g), rd, resp);
      chk(rd, {24'h00_0000, exp_rd(g)});
      chk({30'h0, resp}, {30'h0, `PGD_RESP_OKAY});
      axi_rd(`PGD_FN_F_ADDR + 32'(4 * g), rd, resp);
      chk(rd, {16'h0000, fn[g]});
    end
    chk({8'h00, pullup_en}, {8'h00, exp_pu()});
    chk({31'h0, pin7_oe}, {31'h0, {fn[2][15], fn[2][7]} == `PGD_FN_OUT});
    if (pin7_oe === 1'b1) chk({31'h0, pin7_out}, {31'h0, stored});
  endtask : check_all

  initial begin
    req = '0;
    rst_n = 1'b0;
    ext_lvl = 24'h00_0000;
    ext7_drv = 1'b1;
    stored = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    for (int g = 0; g < 3; g++) fn[g] = `PGD_FN_RESET;
    void'($urandom(32'hc7b3));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    ext_lvl <= 24'($urandom());
    repeat (6) @(posedge sys_clk);
    check_all();
    for (int i = 0; i < 24; i++) begin
      for (int g = 0; g < 3; g++)
        set_fn(g, (i < 4) ? {{8{i[1]}}, {8{i[0]}}} : 16'($urandom()));
      ext_lvl <= 24'($urandom());
      ext7_drv <= ($urandom() % 2 == 1) && ({fn[2][15], fn[2][7]} != `PGD_FN_OUT);
      for (int g = 0; g < 3; g++) begin
        d = $urandom();
        axi_wr(dat_addr(g), d, resp);
        if (g == 2) stored = d[7];
        chk({30'h0, resp}, {30'h0, `PGD_RESP_OKAY});
      end
      repeat (5) @(posedge sys_clk);
      check_all();
    end
    axi_wr(32'h1000_0000, 32'hffff_ffff, resp);
    chk({30'h0, resp}, {30'h0, `PGD_RESP_SLVERR});
    axi_rd(32'h1000_0000, rd, resp);
    chk(rd, 32'h0000_0000);
    chk({30'h0, resp}, {30'h0, `PGD_RESP_SLVERR});
    ext7_drv <= 1'b0;
    axi_wr(`PGD_H_ADDR, 32'h0000_0080, resp);
    stored = 1'b1;
    set_fn(2, 16'h7f80);
    check_all();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    stored = 1'b0;
    for (int g = 0; g < 3; g++) fn[g] = `PGD_FN_RESET;
    repeat (6) @(posedge sys_clk);
    check_all();
    set_fn(2, 16'h7f80);
    check_all();
    close_out();
  end
endmodule : test_pgd_port_fgh
